// ---- inc/ppm_pkg.sv ----
package ppm_pkg;
   // Register byte addresses on the APB slave.
   localparam logic [7:0] ADDR_P1_DIR   = 8'h00;
   localparam logic [7:0] ADDR_P3_DIR   = 8'h04;
   localparam logic [7:0] ADDR_P4_DIR   = 8'h08;
   localparam logic [7:0] ADDR_PULLUP_L = 8'h0C;
   localparam logic [7:0] ADDR_PULLUP_H = 8'h10;
   localparam logic [7:0] ADDR_DRIVE    = 8'h14;
   localparam logic [7:0] ADDR_PERIPH   = 8'h18;
   localparam logic [7:0] ADDR_CLOCK    = 8'h1C;
   localparam logic [7:0] ADDR_PIN_IN   = 8'h20;
   localparam logic [7:0] ADDR_PIN_OUT  = 8'h24;
   // Peripheral control field positions.
   localparam int S0_MODE_LO = 0;
   localparam int S0_MODE_HI = 2;
   localparam int S0_SERIAL_CLOCK_DIRECTION   = 3;
   localparam int S0_OD      = 4;
   localparam int S1_MODE_LO = 5;
   localparam int S1_MODE_HI = 7;
   localparam int S1_OD      = 8;
   localparam int S1_TXEN    = 9;
   localparam int TX_MODE_LO = 10;
   localparam int TX_MODE_HI = 11;
   localparam int TX_OE      = 12;
   localparam int TZ_MODE_LO = 13;
   localparam int TZ_MODE_HI = 14;
   localparam int TZ_OCTL    = 15;
   localparam int TY_MODE1   = 16;
   localparam int IRQ0_EN    = 17;
   localparam int PERIPH_W   = 18;
   // Clock control bit positions.
   localparam int OSC_SEL    = 0;
   localparam int CLK_STOP   = 1;
   localparam int MAIN_DIS   = 2;
   // Field codes.
   localparam logic [1:0] MODE2_NONE  = 2'b00;
   localparam logic [1:0] MODE2_01    = 2'b01;
   localparam logic [2:0] S0_CLKOUT   = 3'b010;
   localparam logic [7:0] DIR_RESET   = 8'h00;
   localparam logic [7:0] ZERO8       = 8'h00;

   // Pin decode result for one pin.
   typedef struct packed {
      logic out_en;
      logic out_val;
      logic high_drive;
      logic open_drain;
      logic pull_up;
   } ppm_pin_t;

   // Crystal pin circuit state.
   typedef struct packed {
      logic osc_buffer;
      logic feedback;
      logic ext_clock;
      logic xout_high;
      logic port_mode;
   } ppm_xtal_t;
endpackage : ppm_pkg

// ---- sim/ppm_port_mux_monitor.sv ----
`timescale 1ns/1ps
// Watches the pin mux ports and ties pin functions to register writes.
module ppm_port_mux_monitor
   import ppm_pkg::*;
(
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pwrite,
   input wire logic [7:0]               paddr,
   input wire logic [31:0]              pwdata,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire ppm_pkg::ppm_pin_t [15:0] pin_q,
   input wire ppm_pkg::ppm_xtal_t       xtal_q
);
   import ppm_pkg::*;
   logic        wr_seen_q;
   logic        wr_acc;
   logic        mapped;
   logic [15:0] oe_v;
   logic [15:0] pu_v;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A completed write and a decoded address, shared by the properties.
   assign wr_acc = psel && penable && pwrite && pready;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_PIN_OUT);

   // Flattened enables, so that one property covers every pin.
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         oe_v[i] = pin_q[i].out_en;
         pu_v[i] = pin_q[i].pull_up;
      end
   end

   // Ends the quiet period after reset; only a new reset clears it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wr_seen_q <= 1'b0;
      else if (wr_acc) wr_seen_q <= 1'b1;
   end

   sequence s_wr(logic [7:0] a);
      wr_acc && (paddr == a);
   endsequence

   chk_ready_after_reset: assert property ($past(presetn) |-> pready)
      else $error("pready low outside reset");
   chk_bus_err_map: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr does not match address decode");
   chk_reset_inputs: assert property (!wr_seen_q |-> oe_v == 16'h0000)
      else $error("pin driven before any write");
   chk_pull_input_only: assert property ((pu_v & oe_v) == 16'h0000)
      else $error("pull-up on a driven pin");
   // An open-drain pin only ever pulls low.
   property p_od0;
      pin_q[0].open_drain |-> pin_q[0].out_en == !pin_q[0].out_val;
   endproperty
   property p_od1;
      pin_q[8].open_drain |-> pin_q[8].out_en == !pin_q[8].out_val;
   endproperty
   // A write lands at its access edge; the pin flop shows it two edges later.
   property p_tx0_drive;
      s_wr(ADDR_PERIPH) ##0 ((pwdata[S0_MODE_HI] || pwdata[S0_MODE_LO]) && !pwdata[S0_OD])
         |-> ##2 pin_q[0].out_en;
   endproperty
   property p_cnt_a_drive;
      s_wr(ADDR_PERIPH) ##0 (pwdata[TX_MODE_HI:TX_MODE_LO] == MODE2_01)
         |-> ##2 pin_q[3].out_en;
   endproperty
   property p_tz_drive;
      s_wr(ADDR_PERIPH) ##0 pwdata[TZ_MODE_HI] |-> ##2 pin_q[5].out_en;
   endproperty
   property p_xtal_ext;
      s_wr(ADDR_CLOCK) ##0 (pwdata[2:0] == 3'b101) |-> ##2
         (xtal_q.ext_clock && xtal_q.xout_high && xtal_q.feedback && !xtal_q.osc_buffer);
   endproperty
   property p_xtal_port;
      s_wr(ADDR_CLOCK) ##0 !pwdata[OSC_SEL] |-> ##2
         (xtal_q.port_mode && !xtal_q.feedback && !xtal_q.osc_buffer);
   endproperty

   chk_od_serial0: assert property (p_od0)
      else $error("serial0 open drain drives high");
   chk_od_serial1: assert property (p_od1)
      else $error("serial1 open drain drives high");
   chk_tx0_drive: assert property (p_tx0_drive)
      else $error("serial0 transmit pin not driven");
   chk_cnt_a_drive: assert property (p_cnt_a_drive)
      else $error("counter-A pin not driven");
   chk_tz_drive: assert property (p_tz_drive)
      else $error("timer-Z pin not driven");
   chk_xtal_ext: assert property (p_xtal_ext)
      else $error("crystal external clock state wrong");
   chk_xtal_port: assert property (p_xtal_port)
      else $error("crystal port state wrong");
endmodule : ppm_port_mux_monitor

bind ppm_port_mux ppm_port_mux_monitor i_ppm_port_mux_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .pin_q(pin_q), .xtal_q(xtal_q)
);

// ---- sim/ppm_port_mux_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the pin function mux.
module ppm_port_mux_tb;
   import ppm_pkg::*;
   localparam int CYC_MAX = 5000;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic pready, pslverr, xin_in = 1'b0, ext_clock_in;
   logic [15:0] pin_in = 16'h0000;
   logic [5:0] po = 6'h00;
   logic s0_rx, s0_ck, s1_rx, irq0, irq1, irq2, irq3, tc_in, ca_in, cb_in;
   logic [9:0] pins_o;
   ppm_pin_t [15:0] pin_q;
   ppm_xtal_t xtal_q;
   int n_errors = 0, n_checks = 0, cyc = 0;
   int seed = 32'h3e10708f;
   logic [32:0] exp_q[$];
   logic [2:0] xc[4] = '{3'b000, 3'b001, 3'b111, 3'b101};
   logic [4:0] xe[4] = '{5'h01, 5'h18, 5'h00, 5'h0E};

   assign pins_o = {cb_in, ca_in, tc_in, irq3, irq2, irq1, irq0, s1_rx, s0_ck, s0_rx};

   ppm_port_mux i_ppm_port_mux (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .xin_in(xin_in),
      .serial0_tx(po[0]), .serial0_clk_int(po[1]), .serial1_tx(po[2]),
      .counter_a_out(po[3]), .counter_b_out(po[4]), .timer_z_out(po[5]),
      .serial0_receive(s0_rx), .serial0_clock(s0_ck), .serial1_receive(s1_rx),
      .irq_zero(irq0), .irq_one(irq1), .irq_two(irq2), .irq_three(irq3),
      .timer_c_capture_in(tc_in), .counter_a_in(ca_in), .counter_b_in(cb_in),
      .ext_clock_in(ext_clock_in), .pin_q(pin_q), .xtal_q(xtal_q));

   always #12.5 pclk = ~pclk;

   task automatic finish_test();
      $display("n_errors=%0d n_checks=%0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({32'h0, got}, {32'h0, exp});
   endtask : chk_bit

   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic settle();
      repeat (4) @(posedge pclk);
      #1;
   endtask : settle

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      exp_q.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      settle();
   endtask : wr

   // Pin k drives peripheral output j, both levels, CMOS or open drain.
   task automatic drv(input int k, input int j, input logic od);
      logic [5:0] v;
      v = 6'($random(seed));
      for (int n = 0; n < 2; n++) begin
         @(posedge pclk);
         po <= v;
         settle();
         chk_bit(pin_q[k].out_val, v[j]);
         chk_bit(pin_q[k].out_en, od ? !v[j] : 1'b1);
         chk_bit(pin_q[k].open_drain, od);
         v = ~v;
      end
   endtask : drv

   // Pin k reaches peripheral input j when routed; otherwise the input idles high.
   task automatic follow(input int k, input int j, input logic routed);
      logic [15:0] v;
      v = 16'($random(seed));
      for (int n = 0; n < 2; n++) begin
         @(posedge pclk);
         pin_in <= v;
         settle();
         chk_bit(pins_o[j], routed ? v[k] : 1'b1);
         v = ~v;
      end
   endtask : follow

   // Read results are compared in order as they complete on the bus.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
         chk_word({pslverr, prdata}, exp_q.pop_front());
   end

   // Cuts a hang short after far more cycles than the sequence needs.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == CYC_MAX) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      logic [31:0] v;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      for (int i = 0; i < 10; i++) chk_bit(pin_q[i].out_en, 1'b0);
      chk_bit(xtal_q.port_mode, 1'b1);
      for (int a = 0; a < 10; a++) rd(8'(4 * a), 33'h0);
      apb(1'b1, 8'h40, 32'hFFFFFFFF);
      rd(8'h40, {1'b1, 32'h0});
      rd(ADDR_PERIPH, 33'h0);
      v = $random(seed);
      apb(1'b1, ADDR_PERIPH, v);
      rd(ADDR_PERIPH, {1'b0, v & 32'h0003FFFF});
      apb(1'b1, ADDR_P1_DIR, v);
      rd(ADDR_P1_DIR, {1'b0, v & 32'h000000FF});
      wr(ADDR_P1_DIR, 32'h0);
      wr(ADDR_PERIPH, 32'h0);
      follow(1, 0, 1'b1);
      wr(ADDR_PULLUP_L, 32'h08);
      follow(1, 0, 1'b0);
      chk_bit(pin_q[1].pull_up, 1'b1);
      wr(ADDR_P1_DIR, 32'h20);
      chk_bit(pin_q[1].pull_up, 1'b0);
      chk_bit(pin_q[1].out_en, 1'b1);
      wr(ADDR_PIN_OUT, 32'h00000002);
      chk_bit(pin_q[1].out_val, 1'b1);
      rd(ADDR_PIN_OUT, 33'h000000002);
      chk_bit(pin_q[1].high_drive, 1'b0);
      wr(ADDR_DRIVE, 32'h30);
      chk_bit(pin_q[1].high_drive, 1'b1);
      wr(ADDR_P1_DIR, 32'h0);
      wr(ADDR_PULLUP_L, 32'h0);
      for (int i = 1; i < 8; i++) begin
         if (i[1:0] != 2'b00) begin
            wr(ADDR_PERIPH, 32'(i[2]) << S0_OD | 32'(i[1]) << S0_MODE_HI | 32'(i[0]));
            drv(0, 0, i[2]);
            chk_bit(pin_q[0].high_drive, 1'b1);
         end
      end
      wr(ADDR_PERIPH, 32'h00000001);
      drv(2, 1, 1'b0);
      wr(ADDR_PERIPH, 32'h00000008);
      chk_bit(pin_q[2].out_en, 1'b0);
      follow(2, 1, 1'b1);
      wr(ADDR_PERIPH, 32'(MODE2_01) << TX_MODE_LO);
      drv(3, 3, 1'b0);
      wr(ADDR_PERIPH, 32'h00000800);
      chk_bit(pin_q[3].out_en, 1'b0);
      follow(3, 8, 1'b1);
      follow(3, 4, 1'b1);
      wr(ADDR_PERIPH, 32'h00001000);
      drv(4, 3, 1'b0);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_PERIPH, 32'(i) << TZ_MODE_LO);
         chk_bit(pin_q[5].out_en, i[1] || (i[1:0] == 2'b01 && !i[2]));
      end
      drv(5, 5, 1'b0);
      wr(ADDR_PERIPH, 32'h00010000);
      drv(6, 4, 1'b0);
      wr(ADDR_PERIPH, 32'h00008000);
      chk_bit(pin_q[6].out_en, 1'b0);
      follow(6, 9, 1'b1);
      follow(6, 5, 1'b1);
      follow(7, 7, 1'b1);
      follow(7, 6, 1'b1);
      wr(ADDR_P3_DIR, 32'h08);
      chk_bit(pin_q[7].out_en, 1'b1);
      follow(7, 6, 1'b0);
      wr(ADDR_PERIPH, 32'h00000220);
      drv(8, 2, 1'b0);
      wr(ADDR_PERIPH, 32'h00000320);
      drv(8, 2, 1'b1);
      wr(ADDR_PERIPH, 32'h00000020);
      follow(8, 2, 1'b1);
      wr(ADDR_PERIPH, 32'h00020000);
      follow(9, 3, 1'b1);
      wr(ADDR_P4_DIR, 32'h20);
      chk_bit(pin_q[9].out_en, 1'b1);
      follow(9, 3, 1'b0);
      rd(ADDR_PIN_IN, {17'h0, pin_in});
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CLOCK, {29'h0, xc[i]});
         chk_word({28'h0, xtal_q}, {28'h0, xe[i]});
      end
      for (int n = 0; n < 2; n++) begin
         @(posedge pclk);
         xin_in <= !n[0];
         settle();
         chk_bit(ext_clock_in, !n[0]);
      end
      finish_test();
   end
endmodule : ppm_port_mux_tb

// ---- src/ppm_pin_cell.sv ----
`timescale 1ns/1ps
// One pin: chooses peripheral or port drive and registers the result.
module ppm_pin_cell
   import ppm_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          dir_out,
   input  wire logic          pull_grp,
   input  wire logic          hi_drv,
   input  wire logic          port_val,
   input  wire logic          periph_en,
   input  wire logic          periph_val,
   input  wire logic          periph_od,
   output ppm_pkg::ppm_pin_t  pin_q
);
   ppm_pin_t pin_d;

   // A peripheral output wins over the direction bit.
   always_comb begin
      pin_d            = '0;
      pin_d.high_drive = hi_drv;
      if (periph_en) begin
         pin_d.open_drain = periph_od;
         pin_d.out_val    = periph_val;
         // Open-drain releases the wire for a one.
         pin_d.out_en     = periph_od ? ~periph_val : 1'b1;
      end else begin
         pin_d.out_en  = dir_out;
         pin_d.out_val = port_val;
         pin_d.pull_up = pull_grp & ~dir_out;
      end
   end

   // Registered so that every pin output comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= '0;
      end else begin
         pin_q <= pin_d;
      end
   end
endmodule : ppm_pin_cell

// ---- src/ppm_port_mux.sv ----
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Pin function mux with APB register file.
module ppm_port_mux
   import ppm_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [15:0]   pin_in,
   input  wire logic          xin_in,
   input  wire logic          serial0_tx,
   input  wire logic          serial0_clk_int,
   input  wire logic          serial1_tx,
   input  wire logic          counter_a_out,
   input  wire logic          counter_b_out,
   input  wire logic          timer_z_out,
   output logic               serial0_receive,
   output logic               serial0_clock,
   output logic               serial1_receive,
   output logic               irq_zero,
   output logic               irq_one,
   output logic               irq_two,
   output logic               irq_three,
   output logic               timer_c_capture_in,
   output logic               counter_a_in,
   output logic               counter_b_in,
   output logic               ext_clock_in,
   output ppm_pkg::ppm_pin_t [15:0] pin_q,
   output ppm_pkg::ppm_xtal_t xtal_q
);
   // Pin index map: 0..3 port1 bits 4..7, 4..7 port3 bits 0..3, 8 port3 bit 7,
   // 9 port4 bit 5, 10..15 unused and parked as inputs.
   localparam int NPIN = 16;

   // Software-visible registers, one aligned word each, then the pin and crystal input synchronisers.
   logic [7:0]          port1_direction_q;
   logic [7:0]          port3_direction_q;
   logic [7:0]          port4_direction_q;
   logic [7:0]          pullup_control_low_q;
   logic [7:0]          pullup_control_high_q;
   logic [7:0]          port1_drive_strength_q;
   logic [PERIPH_W-1:0] periph_q;
   logic [2:0]          clock_ctl_q;
   logic [15:0]         port_out_q;
   logic [15:0]         sync1_q;
   logic [15:0]         sync2_q;
   logic [1:0]          xin_sync_q;

   // Bus decode and read path.
   logic                wr_en;
   logic                rd_en;
   logic                addr_ok;
   logic [31:0]         rdata_d;

   // Per-pin control vectors, indexed by the pin map above.
   logic [NPIN-1:0]     dir_v;
   logic [NPIN-1:0]     pull_v;
   logic [NPIN-1:0]     hd_v;
   logic [NPIN-1:0]     pen_v;
   logic [NPIN-1:0]     pval_v;
   logic [NPIN-1:0]     pod_v;

   // Decoded peripheral fields.
   logic [2:0]          s0_mode;
   logic [2:0]          s1_mode;
   logic [1:0]          tx_mode;
   logic [1:0]          tz_mode;
   logic                s0_tx_mode;
   logic                s1_tx_mode;
   logic                s0_idle;
   logic                s1_idle;
   logic                rx0_route;
   logic                ck0_route;
   logic                cnt_a_route;
   logic                cnt_b_route;
   logic                tc_route;
   logic                rx1_route;
   logic                irq0_route;
   logic                ext_clk_mode;

   // Field views of the peripheral control register.
   assign s0_mode    = periph_q[S0_MODE_HI:S0_MODE_LO];
   assign s1_mode    = periph_q[S1_MODE_HI:S1_MODE_LO];
   assign tx_mode    = periph_q[TX_MODE_HI:TX_MODE_LO];
   assign tz_mode    = periph_q[TZ_MODE_HI:TZ_MODE_LO];
   // Transmit modes are 1X or X1 on the two mode bits that matter.
   assign s0_tx_mode = s0_mode[2] | s0_mode[0];
   assign s1_tx_mode = s1_mode[2] | s1_mode[0];
   assign s0_idle    = ~s0_tx_mode;
   assign s1_idle    = ~s1_tx_mode;

   // APB decode; zero wait states, so pready is high from the first edge after reset.
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   always_comb begin
      addr_ok = 1'b1;
      rdata_d = '0;
      unique case (paddr)
         ADDR_P1_DIR:   rdata_d[7:0] = port1_direction_q;
         ADDR_P3_DIR:   rdata_d[7:0] = port3_direction_q;
         ADDR_P4_DIR:   rdata_d[7:0] = port4_direction_q;
         ADDR_PULLUP_L: rdata_d[7:0] = pullup_control_low_q;
         ADDR_PULLUP_H: rdata_d[7:0] = pullup_control_high_q;
         ADDR_DRIVE:    rdata_d[7:0] = port1_drive_strength_q;
         ADDR_PERIPH:   rdata_d[PERIPH_W-1:0] = periph_q;
         ADDR_CLOCK:    rdata_d[2:0] = clock_ctl_q;
         ADDR_PIN_IN:   rdata_d[15:0] = sync2_q;
         ADDR_PIN_OUT:  rdata_d[15:0] = port_out_q;
         default:       addr_ok = 1'b0;
      endcase
   end

   // Register writes; direction bits clear on reset so pins start as inputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port1_direction_q      <= DIR_RESET;
         port3_direction_q      <= DIR_RESET;
         port4_direction_q      <= DIR_RESET;
         pullup_control_low_q   <= ZERO8;
         pullup_control_high_q  <= ZERO8;
         port1_drive_strength_q <= ZERO8;
         periph_q               <= '0;
         clock_ctl_q            <= '0;
         port_out_q             <= '0;
      end else if (wr_en && addr_ok) begin
         unique case (paddr)
            ADDR_P1_DIR:   port1_direction_q      <= pwdata[7:0];
            ADDR_P3_DIR:   port3_direction_q      <= pwdata[7:0];
            ADDR_P4_DIR:   port4_direction_q      <= pwdata[7:0];
            ADDR_PULLUP_L: pullup_control_low_q   <= pwdata[7:0];
            ADDR_PULLUP_H: pullup_control_high_q  <= pwdata[7:0];
            ADDR_DRIVE:    port1_drive_strength_q <= pwdata[7:0];
            ADDR_PERIPH:   periph_q               <= pwdata[PERIPH_W-1:0];
            ADDR_CLOCK:    clock_ctl_q            <= pwdata[2:0];
            ADDR_PIN_OUT:  port_out_q             <= pwdata[15:0];
            // The pin input word is read only, so a write to it changes nothing.
            default:       port_out_q             <= port_out_q;
         endcase
      end
   end

   // Read data is captured in setup so it stands through the access phase.
   // The error flag is taken at the same edge, so it too stands while penable is high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= 1'b1;
         pslverr <= psel & ~penable & ~addr_ok;
         if (rd_en) begin
            prdata <= rdata_d;
         end
      end
   end

   // Pins come from outside the clock domain, so two flip-flops first.
   // Only the second stage is read anywhere, so a metastable first stage never leaks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         xin_sync_q <= '0;
      end else begin
         sync1_q    <= pin_in;
         sync2_q    <= sync1_q;
         xin_sync_q <= {xin_sync_q[0], xin_in};
      end
   end

   // Per-pin direction, pull group and drive, with peripheral claims.
   always_comb begin
      dir_v  = '0;
      pull_v = '0;
      hd_v   = '0;
      pen_v  = '0;
      pval_v = '0;
      pod_v  = '0;
      dir_v[3:0] = port1_direction_q[7:4];
      dir_v[7:4] = port3_direction_q[3:0];
      dir_v[8]   = port3_direction_q[7];
      dir_v[9]   = port4_direction_q[5];
      // Port1 high nibble is group 3; port3 low nibble group 6, bit 7 group 7.
      pull_v[3:0] = {4{pullup_control_low_q[3]}};
      pull_v[7:4] = {4{pullup_control_low_q[6]}};
      pull_v[8]   = pullup_control_low_q[7];
      pull_v[9]   = pullup_control_high_q[1];
      // Only port1 has the high-drive transistor.
      // Other pins have no drive control, so their bit stays low.
      hd_v[3:0]  = port1_drive_strength_q[7:4];
      // Serial-0 transmit.
      pen_v[0]  = s0_tx_mode;
      pval_v[0] = serial0_tx;
      pod_v[0]  = periph_q[S0_OD];
      // Serial-0 clock out only when mode bit 2, mode bit 0 and the clock direction bit read 010.
      pen_v[2]  = ({s0_mode[2], s0_mode[0], periph_q[S0_SERIAL_CLOCK_DIRECTION]} == S0_CLKOUT);
      pval_v[2] = serial0_clk_int;
      // Counter-A on the port1 pin.
      pen_v[3]  = (tx_mode == MODE2_01);
      pval_v[3] = counter_a_out;
      // Second counter-A pin.
      pen_v[4]  = periph_q[TX_OE];
      pval_v[4] = counter_a_out;
      // Timer-Z output.
      pen_v[5]  = tz_mode[1] | ((tz_mode == MODE2_01) & ~periph_q[TZ_OCTL]);
      pval_v[5] = timer_z_out;
      // Counter-B output.
      pen_v[6]  = periph_q[TY_MODE1] & ~periph_q[TZ_OCTL];
      pval_v[6] = counter_b_out;
      // Serial-1 shared pin transmits only with its pin enable.
      pen_v[8]  = periph_q[S1_TXEN] & s1_tx_mode;
      pval_v[8] = serial1_tx;
      pod_v[8]  = periph_q[S1_OD];
   end

   // One cell per pin; a generate keeps the pins identical.
   // Unused cells are kept so that every pin entry has a defined reset value.
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      ppm_pin_cell u_cell (
         .pclk       (pclk),
         .presetn    (presetn),
         .dir_out    (dir_v[i]),
         .pull_grp   (pull_v[i]),
         .hi_drv     (hd_v[i]),
         .port_val   (port_out_q[i]),
         .periph_en  (pen_v[i]),
         .periph_val (pval_v[i]),
         .periph_od  (pod_v[i]),
         .pin_q      (pin_q[i])
      );
   end

   // Routing conditions for the peripheral inputs. A pulled-up pin is left out on
   // purpose: only the unpulled input settings hand the pin level to a peripheral.
   assign rx0_route    = ~dir_v[1] & ~pull_v[1];
   assign ck0_route    = ~dir_v[2] & ~pull_v[2] & periph_q[S0_SERIAL_CLOCK_DIRECTION];
   assign cnt_a_route  = ~dir_v[3] & ~pull_v[3] & ~pen_v[3];
   assign cnt_b_route  = ~dir_v[6] & ~pull_v[6] & ~pen_v[6];
   assign tc_route     = ~dir_v[7] & ~pull_v[7];
   assign rx1_route    = ~periph_q[S1_TXEN] & ~dir_v[8] & ~pull_v[8] & ~s1_idle;
   assign irq0_route   = ~dir_v[9] & ~pull_v[9] & periph_q[IRQ0_EN];
   assign ext_clk_mode = clock_ctl_q[OSC_SEL] & ~clock_ctl_q[CLK_STOP]
                         & clock_ctl_q[MAIN_DIS];

   // Peripheral inputs: only unpulled inputs feed a peripheral, else idle high; ext_clock_in idles low.
   // Idle high looks like a released line, so no receiver sees a false start bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial0_receive    <= 1'b1;
         serial0_clock      <= 1'b1;
         serial1_receive    <= 1'b1;
         irq_zero           <= 1'b1;
         irq_one            <= 1'b1;
         irq_two            <= 1'b1;
         irq_three          <= 1'b1;
         timer_c_capture_in <= 1'b1;
         counter_a_in       <= 1'b1;
         counter_b_in       <= 1'b1;
         ext_clock_in       <= 1'b0;
      end else begin
         serial0_receive    <= rx0_route ? sync2_q[1] : 1'b1;
         serial0_clock      <= ck0_route ? sync2_q[2] : 1'b1;
         irq_one            <= cnt_a_route ? sync2_q[3] : 1'b1;
         counter_a_in       <= cnt_a_route ? sync2_q[3] : 1'b1;
         irq_two            <= cnt_b_route ? sync2_q[6] : 1'b1;
         counter_b_in       <= cnt_b_route ? sync2_q[6] : 1'b1;
         irq_three          <= tc_route ? sync2_q[7] : 1'b1;
         timer_c_capture_in <= tc_route ? sync2_q[7] : 1'b1;
         serial1_receive    <= rx1_route ? sync2_q[8] : 1'b1;
         irq_zero           <= irq0_route ? sync2_q[9] : 1'b1;
         ext_clock_in       <= ext_clk_mode ? xin_sync_q[1] : 1'b0;
      end
   end

   // Crystal circuit: port mode wins, then stop, then external clock, then oscillation.
   // Only port mode is set at reset, so both crystal pins start as plain inputs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_q <= '0;
         xtal_q.port_mode <= 1'b1;
      end else begin
         xtal_q <= '0;
         if (!clock_ctl_q[OSC_SEL]) begin
            xtal_q.port_mode <= 1'b1;
         end else if (clock_ctl_q[CLK_STOP]) begin
            xtal_q.port_mode <= 1'b0;
         end else if (clock_ctl_q[MAIN_DIS]) begin
            xtal_q.feedback  <= 1'b1;
            xtal_q.ext_clock <= 1'b1;
            xtal_q.xout_high <= 1'b1;
         end else begin
            xtal_q.osc_buffer <= 1'b1;
            xtal_q.feedback   <= 1'b1;
         end
      end
   end
endmodule : ppm_port_mux
